// file: verilog/tcc_compare.sv
// The implementer's own choice: the APB interface to the registers.
`include "tcc_cfg.svh"
//------------------------------------------------------------
//------------------------------------------------------------
module tcc_compare (
  input  wire logic                   clk,                 // 10 MHz clock
  input  wire logic                   sys_rst,             // Sync reset, high
  input  wire logic                   psel,                // APB select
  input  wire logic                   penable,             // APB enable
  input  wire logic                   pwrite,              // APB direction
  input  wire logic [`TCC_ADDR_W-1:0] paddr,               // APB byte address
  input  wire logic [31:0]            pwdata,              // APB write data
  output logic      [31:0]            prdata,              // APB read data
  output logic                        pready,              // APB ready
  output logic                        pslverr,             // APB error
  input  wire logic                   timer_tick,          // Prescaled tick
  input  wire logic [7:0]             timer_count,         // Counter value
  input  wire logic                   timer_count_down,    // Counter moving down
  input  wire logic [1:0]             timer_mode,          // Counter mode
  output logic                        channel0_pin,        // Channel 0 output
  output logic                        channel1_pin,        // Channel 1 output
  output logic                        channel0_dma_trigger, // DMA pulse ch0
  output logic                        channel1_dma_trigger, // DMA pulse ch1
  output logic                        cpu_timer_irq_flag,  // Level interrupt
  output logic      [1:0]             shared_timer_flags   // Sticky match flags
);
  logic [7:0] channel0_compare_control;
  logic [7:0] channel1_compare_control;
  logic [7:0] channel0_match_value;
  logic [7:0] channel1_match_value;
  logic [1:0] irq_mask;
  logic [1:0] match;
  logic [1:0] pins;
  logic [1:0] irq_en;
  logic [1:0] next_flags;
  logic       wr_en;
  logic       aligned;
  logic [7:0] index;
  logic [7:0] rd_byte;
  logic       mapped;
  logic       updown;
  logic [7:0] alt0_value;
  logic [2:0] act0;
  logic [2:0] act1;
  logic       live0;
  logic       live1;

  // Every check below runs on the one system clock and sleeps in reset
  default clocking tcc_cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Control byte as stored: bit 7 forced low
  function automatic logic [7:0] ctl_write(input logic [7:0] d);
    ctl_write = {1'b0, d[6:0]};
  endfunction

  //------------------------------------------------------------
  // Bus decode
  //------------------------------------------------------------
  tcc_apb_slave u_apb (
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .wr_en   (wr_en),
    .rd_en   (),
    .index   (index),
    .aligned (aligned)
  );

  assign updown = (timer_mode == `TCC_MODE_UPDOWN);
  assign act0   = channel0_compare_control[`TCC_ACT_HI:`TCC_ACT_LO];
  assign act1   = channel1_compare_control[`TCC_ACT_HI:`TCC_ACT_LO];
  assign live0  = timer_tick && channel0_compare_control[`TCC_EN_BIT];
  assign live1  = timer_tick && channel1_compare_control[`TCC_EN_BIT];
  assign irq_en = {channel1_compare_control[`TCC_IRQEN_BIT],
                   channel0_compare_control[`TCC_IRQEN_BIT]};

  always_comb begin
    mapped  = 1'b1;
    rd_byte = 8'h00;
    case (index)
      `TCC_IDX_CTL0:    rd_byte = channel0_compare_control;
      `TCC_IDX_VAL0:    rd_byte = channel0_match_value;
      `TCC_IDX_CTL1:    rd_byte = channel1_compare_control;
      `TCC_IDX_VAL1:    rd_byte = channel1_match_value;
      `TCC_IDX_STATUS:  rd_byte = {6'h00, shared_timer_flags};
      `TCC_IDX_MASK:    rd_byte = {6'h00, irq_mask};
      `TCC_IDX_OUTPUTS: rd_byte = {6'h00, pins};
      default:          mapped  = 1'b0;
    endcase
  end

  // Zero-wait answer; pready held high so every access completes in one cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= 1'b1;
      pslverr <= psel && !penable && !(mapped && aligned);
      prdata  <= (psel && !penable) ? {24'h000000, rd_byte} : prdata;
    end
  end

  //------------------------------------------------------------
  // Registers
  //------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      channel0_compare_control <= `TCC_CTL_RESET;
      channel1_compare_control <= `TCC_CTL_RESET;
    end else if (wr_en) begin
      // Reserved bits 1:0 are stored as written; software keeps them zero
      if (index == `TCC_IDX_CTL0) channel0_compare_control <= ctl_write(pwdata[7:0]);
      if (index == `TCC_IDX_CTL1) channel1_compare_control <= ctl_write(pwdata[7:0]);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      channel0_match_value <= `TCC_VAL_RESET;
      channel1_match_value <= `TCC_VAL_RESET;
      irq_mask             <= `TCC_MASK_RESET;
    end else if (wr_en) begin
      if (index == `TCC_IDX_VAL0) channel0_match_value <= pwdata[7:0];
      if (index == `TCC_IDX_VAL1) channel1_match_value <= pwdata[7:0];
      if (index == `TCC_IDX_MASK) irq_mask <= pwdata[1:0];
    end
  end

  //------------------------------------------------------------
  // Channels
  //------------------------------------------------------------
  // Channel 0 code 101 clears at the top count but code 110 sets at zero,
  // so its second compare value follows its own action field
  assign alt0_value = (act0 == tcc_pkg::ACT_CLR_ALT) ? `TCC_CNT_ZERO : `TCC_CNT_TOP;

  tcc_channel u_ch0 (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .tick       (timer_tick),
    .count      (timer_count),
    .count_down (timer_count_down),
    .updown     (updown),
    .ctl        (channel0_compare_control),
    .value      (channel0_match_value),
    .alt_value  (alt0_value),
    .match      (match[0]),
    .pin        (pins[0])
  );

  tcc_channel u_ch1 (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .tick       (timer_tick),
    .count      (timer_count),
    .count_down (timer_count_down),
    .updown     (updown),
    .ctl        (channel1_compare_control),
    .value      (channel1_match_value),
    .alt_value  (channel0_match_value),
    .match      (match[1]),
    .pin        (pins[1])
  );

  //------------------------------------------------------------
  // Flags, interrupt, DMA
  //------------------------------------------------------------
  // Set wins over a write-one clear in the same cycle
  always_comb begin
    next_flags = shared_timer_flags;
    if (wr_en && index == `TCC_IDX_STATUS) next_flags = next_flags & ~pwdata[1:0];
    next_flags = next_flags | match;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shared_timer_flags   <= 2'h0;
      cpu_timer_irq_flag   <= 1'b0;
      channel0_dma_trigger <= 1'b0;
      channel1_dma_trigger <= 1'b0;
      channel0_pin         <= 1'b0;
      channel1_pin         <= 1'b0;
    end else begin
      shared_timer_flags   <= next_flags;
      cpu_timer_irq_flag   <= |(next_flags & irq_en & irq_mask);
      channel0_dma_trigger <= match[0];
      channel1_dma_trigger <= match[1];
      channel0_pin         <= pins[0];
      channel1_pin         <= pins[1];
    end
  end

  //------------------------------------------------------------
  // Assertions
  //------------------------------------------------------------
  a_dma_follows_match: assert property (@(posedge clk) disable iff (sys_rst)
    match[0] |=> channel0_dma_trigger) else $error("ch0 dma missing");
  a_flag_sticks: assert property (@(posedge clk) disable iff (sys_rst)
    match[1] |=> shared_timer_flags[1]) else $error("ch1 flag not set");
  a_irq_gated: assert property (@(posedge clk) disable iff (sys_rst)
    cpu_timer_irq_flag |-> $past(irq_en) != 2'h0) else $error("irq while disabled");
  a_no_match_disabled: assert property (@(posedge clk) disable iff (sys_rst)
    match[0] |-> $past(channel0_compare_control[`TCC_EN_BIT])) else $error("match disabled");
  a_match_on_tick: assert property (@(posedge clk) disable iff (sys_rst)
    match[1] |-> $past(timer_tick)) else $error("match without tick");
  a_bit7_zero: assert property (@(posedge clk) disable iff (sys_rst)
    !channel0_compare_control[7] && !channel1_compare_control[7]) else $error("bit7 set");
  a_val0_write: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_en && index == `TCC_IDX_VAL0) |=> channel0_match_value == $past(pwdata[7:0]))
    else $error("val0 write lost");
  a_val1_write: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_en && index == `TCC_IDX_VAL1) |=> channel1_match_value == $past(pwdata[7:0]))
    else $error("val1 write lost");
  a_set_action: assert property (@(posedge clk) disable iff (sys_rst)
    (match[0] && $past(channel0_compare_control[5:3]) == 3'h0) |=> channel0_pin)
    else $error("set action failed");

  //------------------------------------------------------------
  // Reset and gating
  //------------------------------------------------------------
  a_ctl_reset: assert property (
    $past(sys_rst) |-> channel0_compare_control == `TCC_CTL_RESET
                    && channel1_compare_control == `TCC_CTL_RESET)
    else $error("control reset value wrong");
  a_val_reset: assert property (
    $past(sys_rst) |-> channel0_match_value == `TCC_VAL_RESET
                    && channel1_match_value == `TCC_VAL_RESET)
    else $error("match value reset wrong");
  a_en_gates_ch1: assert property (
    match[1] |->
      $past(channel1_compare_control[`TCC_EN_BIT]))
    else $error("ch1 match while disabled");
  a_ch0_needs_tick: assert property (
    match[0] |->
      $past(timer_tick))
    else $error("ch0 match without tick");
  a_idle_no_match: assert property (
    !timer_tick |=>
      match == 2'h0)
    else $error("match on idle cycle");

  //------------------------------------------------------------
  // Flags, interrupt and DMA
  //------------------------------------------------------------
  a_dma1_follows_match: assert property (
    match[1] |=>
      channel1_dma_trigger)
    else $error("ch1 dma missing");
  a_dma0_from_match: assert property (
    channel0_dma_trigger |->
      $past(match[0]))
    else $error("ch0 dma without match");
  a_flag0_set: assert property (
    match[0] |=>
      shared_timer_flags[0])
    else $error("ch0 flag not set");
  a_flag0_holds: assert property (
    shared_timer_flags[0] && !(wr_en && index == `TCC_IDX_STATUS && pwdata[0]) |=>
      shared_timer_flags[0])
    else $error("ch0 flag lost");
  a_flag0_clear: assert property (
    wr_en && index == `TCC_IDX_STATUS && pwdata[0] && !match[0] |=>
      !shared_timer_flags[0])
    else $error("ch0 flag not cleared");
  a_irq_needs_flag: assert property (
    cpu_timer_irq_flag |->
      shared_timer_flags != 2'h0)
    else $error("irq without flag");
  a_irq_mask_closed: assert property (
    $past(irq_mask) == 2'h0 |->
      !cpu_timer_irq_flag)
    else $error("irq with mask closed");

  //------------------------------------------------------------
  // Pin actions
  //------------------------------------------------------------
  // A pin moves two edges after the tick edge: one in the channel, one
  // in the output flop, so a match seen here shows on the pin next cycle
  a_clr_action: assert property (
    match[0] && $past(act0) == tcc_pkg::ACT_CLR |=>
      !channel0_pin)
    else $error("clear action failed");
  a_tog_action: assert property (
    match[0] && $past(act0) == tcc_pkg::ACT_TOG |=>
      channel0_pin != $past(channel0_pin))
    else $error("toggle action failed");
  a_set_action_ch1: assert property (
    match[1] && $past(act1) == tcc_pkg::ACT_SET |=>
      channel1_pin)
    else $error("ch1 set action failed");
  a_up_set_action: assert property (
    match[0] && $past(act0) == tcc_pkg::ACT_SET_UP && !$past(updown) |=>
      channel0_pin)
    else $error("code 011 up set failed");
  a_up_clr_action: assert property (
    match[0] && $past(act0) == tcc_pkg::ACT_CLR_UP && !$past(updown) |=>
      !channel0_pin)
    else $error("code 100 up clear failed");
  a_zero_clr_action: assert property (
    live0 && act0 == tcc_pkg::ACT_SET_UP && !updown
      && timer_count == `TCC_CNT_ZERO && timer_count != channel0_match_value |->
      ##2 !channel0_pin)
    else $error("code 011 zero clear failed");
  a_zero_set_action: assert property (
    live0 && act0 == tcc_pkg::ACT_CLR_UP && !updown
      && timer_count == `TCC_CNT_ZERO && timer_count != channel0_match_value |->
      ##2 channel0_pin)
    else $error("code 100 zero set failed");
  a_down_clr_action: assert property (
    match[0] && $past(act0) == tcc_pkg::ACT_SET_UP
      && $past(updown) && $past(timer_count_down) |=>
      !channel0_pin)
    else $error("code 011 down clear failed");
  a_down_set_action: assert property (
    match[0] && $past(act0) == tcc_pkg::ACT_CLR_UP
      && $past(updown) && $past(timer_count_down) |=>
      channel0_pin)
    else $error("code 100 down set failed");
  a_top0_clear: assert property (
    live0 && act0 == tcc_pkg::ACT_SET_ALT
      && timer_count == `TCC_CNT_TOP && timer_count != channel0_match_value |->
      ##2 !channel0_pin)
    else $error("code 101 top clear failed");
  a_zero0_set: assert property (
    live0 && act0 == tcc_pkg::ACT_CLR_ALT
      && timer_count == `TCC_CNT_ZERO && timer_count != channel0_match_value |->
      ##2 channel0_pin)
    else $error("code 110 zero set failed");
  a_alt1_clear: assert property (
    live1 && act1 == tcc_pkg::ACT_SET_ALT
      && timer_count == channel0_match_value && timer_count != channel1_match_value |->
      ##2 !channel1_pin)
    else $error("ch1 code 101 clear failed");

  c_ch0_match: cover property (@(posedge clk) match[0]);
  c_ch1_match: cover property (@(posedge clk) match[1]);
  c_irq: cover property (@(posedge clk) cpu_timer_irq_flag);
  c_updown: cover property (@(posedge clk) updown && match[0]);
  c_ch1_alt: cover property (@(posedge clk) live1 && act1 == tcc_pkg::ACT_SET_ALT);
endmodule

// file: inc/tcc_cfg.svh
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH
// Register indices; the byte address on the bus is four times the index
`define TCC_IDX_CTL0    8'hcc
`define TCC_IDX_VAL0    8'hcd
`define TCC_IDX_CTL1    8'hce
`define TCC_IDX_VAL1    8'hcf
`define TCC_IDX_STATUS  8'hd0
`define TCC_IDX_MASK    8'hd1
`define TCC_IDX_OUTPUTS 8'hd2
`define TCC_ADDR_W      10
// Control register fields
`define TCC_IRQEN_BIT   6
`define TCC_ACT_HI      5
`define TCC_ACT_LO      3
`define TCC_EN_BIT      2
`define TCC_RSV_HI      1
`define TCC_RSV_LO      0
`define TCC_CTL_RESET   8'h40
`define TCC_VAL_RESET   8'h00
`define TCC_MASK_RESET  2'h3
`define TCC_CNT_TOP     8'hff
`define TCC_CNT_ZERO    8'h00
`define TCC_MODE_UPDOWN 2'h3
`define TCC_ST_W        2
`endif

// file: inc/tcc_pkg.sv
package tcc_pkg;
  typedef enum logic [2:0] {
    ACT_SET      = 3'b000,
    ACT_CLR      = 3'b001,
    ACT_TOG      = 3'b010,
    ACT_SET_UP   = 3'b011,
    ACT_CLR_UP   = 3'b100,
    ACT_SET_ALT  = 3'b101,
    ACT_CLR_ALT  = 3'b110,
    ACT_UNUSED   = 3'b111
  } tcc_action_t;
endpackage

// file: verilog/tcc_channel.sv
`include "tcc_cfg.svh"
// One compare channel: match detect and pin action
module tcc_channel (
  input  wire logic       clk,        // System clock
  input  wire logic       sys_rst,    // Sync reset, high
  input  wire logic       tick,       // Active timer tick
  input  wire logic [7:0] count,      // Counter value
  input  wire logic       count_down, // Counter moving down
  input  wire logic       updown,     // Up/down mode
  input  wire logic [7:0] ctl,        // Control register
  input  wire logic [7:0] value,      // Own match value
  input  wire logic [7:0] alt_value,  // Second event value
  output logic            match,      // Match pulse
  output logic            pin         // Output pin
);
  logic        live;
  logic        hit;
  logic        at_zero;
  logic        at_alt;
  logic        next_pin;
  tcc_pkg::tcc_action_t act;

  assign act     = tcc_pkg::tcc_action_t'(ctl[`TCC_ACT_HI:`TCC_ACT_LO]);
  assign live    = tick && ctl[`TCC_EN_BIT];
  assign hit     = live && (count == value);
  assign at_zero = live && (count == `TCC_CNT_ZERO);
  assign at_alt  = live && (count == alt_value);

  always_comb begin
    next_pin = pin;
    case (act)
      tcc_pkg::ACT_SET:    if (hit) next_pin = 1'b1;
      tcc_pkg::ACT_CLR:    if (hit) next_pin = 1'b0;
      tcc_pkg::ACT_TOG:    if (hit) next_pin = ~pin;
      tcc_pkg::ACT_SET_UP: begin
        if (updown) begin
          if (hit) next_pin = ~count_down;
        end else if (hit) begin
          next_pin = 1'b1;
        end else if (at_zero) begin
          next_pin = 1'b0;
        end
      end
      tcc_pkg::ACT_CLR_UP: begin
        if (updown) begin
          if (hit) next_pin = count_down;
        end else if (hit) begin
          next_pin = 1'b0;
        end else if (at_zero) begin
          next_pin = 1'b1;
        end
      end
      tcc_pkg::ACT_SET_ALT: begin
        if (hit) next_pin = 1'b1;
        else if (at_alt) next_pin = 1'b0;
      end
      tcc_pkg::ACT_CLR_ALT: begin
        if (hit) next_pin = 1'b0;
        else if (at_alt) next_pin = 1'b1;
      end
      default: next_pin = pin;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin   <= 1'b0;
      match <= 1'b0;
    end else begin
      pin   <= next_pin;
      match <= hit;
    end
  end
endmodule

// file: verilog/tcc_apb_slave.sv
`include "tcc_cfg.svh"
// Minimal zero-wait APB decode
module tcc_apb_slave (
  input  wire logic                   psel,    // APB select
  input  wire logic                   penable, // APB enable
  input  wire logic                   pwrite,  // APB direction
  input  wire logic [`TCC_ADDR_W-1:0] paddr,   // APB byte address
  output logic                        wr_en,   // Write strobe
  output logic                        rd_en,   // Read strobe
  output logic [7:0]                  index,   // Register index
  output logic                        aligned  // Word aligned
);
  assign aligned = (paddr[1:0] == 2'h0);
  assign index   = paddr[`TCC_ADDR_W-1:2];
  assign wr_en   = psel && penable && pwrite && aligned;
  assign rd_en   = psel && penable && !pwrite;
endmodule

// file: verification/tb.sv
`include "tcc_cfg.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  //------------------------------------------------------------
  // Stimulus and observation
  //------------------------------------------------------------
  `define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin mismatches++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
  localparam logic [`TCC_ADDR_W-1:0] A_CTL0 = {`TCC_IDX_CTL0, 2'b00};
  localparam logic [`TCC_ADDR_W-1:0] A_VAL0 = {`TCC_IDX_VAL0, 2'b00};
  localparam logic [`TCC_ADDR_W-1:0] A_CTL1 = {`TCC_IDX_CTL1, 2'b00};
  localparam logic [`TCC_ADDR_W-1:0] A_VAL1 = {`TCC_IDX_VAL1, 2'b00};
  localparam logic [`TCC_ADDR_W-1:0] A_STAT = {`TCC_IDX_STATUS, 2'b00};
  localparam logic [`TCC_ADDR_W-1:0] A_MASK = {`TCC_IDX_MASK, 2'b00};
  logic                   clk;
  logic                   sys_rst;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic [`TCC_ADDR_W-1:0] paddr;
  logic [31:0]            pwdata;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic                   timer_tick;
  logic [7:0]             timer_count;
  logic                   timer_count_down;
  logic [1:0]             timer_mode;
  logic                   channel0_pin;
  logic                   channel1_pin;
  logic                   channel0_dma_trigger;
  logic                   channel1_dma_trigger;
  logic                   cpu_timer_irq_flag;
  logic [1:0]             shared_timer_flags;
  int                     mismatches;
  int                     checks;
  int                     dma0;
  int                     dma1;

  tcc_compare dut_u (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_tick(timer_tick), .timer_count(timer_count),
    .timer_count_down(timer_count_down), .timer_mode(timer_mode),
    .channel0_pin(channel0_pin), .channel1_pin(channel1_pin),
    .channel0_dma_trigger(channel0_dma_trigger), .channel1_dma_trigger(channel1_dma_trigger),
    .cpu_timer_irq_flag(cpu_timer_irq_flag), .shared_timer_flags(shared_timer_flags));

  always #50 clk = ~clk;
  // Pulses are counted rather than sampled so a late or doubled trigger shows up
  always @(posedge clk) begin
    if (channel0_dma_trigger === 1'b1) dma0++;
    if (channel1_dma_trigger === 1'b1) dma1++;
  end

  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Only the watchdog ends a wait for a slave that never answers
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input string nm, input logic [9:0] a, input logic [31:0] ex);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK(nm, ex, r)
  endtask

  // One active tick at a given count; waits out the pin latency of two edges
  task automatic tick(input logic [7:0] c, input logic dn);
    @(posedge clk);
    timer_tick <= 1'b1; timer_count <= c; timer_count_down <= dn;
    @(posedge clk);
    timer_tick <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  //------------------------------------------------------------
  // Scenarios
  //------------------------------------------------------------
  task automatic t_regs;
    logic [31:0] r;
    logic        e;
    rd_chk("ctl0", A_CTL0, 32'h40);
    rd_chk("ctl1", A_CTL1, 32'h40);
    rd_chk("val0", A_VAL0, 32'h0);
    rd_chk("val1", A_VAL1, 32'h0);
    rd_chk("mask", A_MASK, 32'h3);
    wr(A_CTL0, 32'hbc);
    rd_chk("ctl0_b7", A_CTL0, 32'h3c);
    wr(A_VAL1, 32'h1a5);
    rd_chk("val1_wr", A_VAL1, 32'ha5);
    apb(1'b0, 10'h350, 32'h0, r, e);
    `CHK("unmapped_err", 1'b1, e)
    `CHK("unmapped_rd", 32'h0, r)
  endtask

  task automatic t_basic;
    wr(A_VAL0, 32'h20);
    wr(A_CTL0, 32'h40);
    tick(8'h20, 1'b0);
    `CHK("pin0_off", 1'b0, channel0_pin)
    `CHK("dma0_off", 0, dma0)
    wr(A_CTL0, 32'h44);
    tick(8'h21, 1'b0);
    `CHK("pin0_miss", 1'b0, channel0_pin)
    tick(8'h20, 1'b0);
    `CHK("pin0_set", 1'b1, channel0_pin)
    wr(A_CTL0, 32'h4c);
    tick(8'h20, 1'b0);
    `CHK("pin0_clr", 1'b0, channel0_pin)
    wr(A_CTL0, 32'h54);
    tick(8'h20, 1'b0);
    `CHK("pin0_tog1", 1'b1, channel0_pin)
    tick(8'h20, 1'b0);
    `CHK("pin0_tog2", 1'b0, channel0_pin)
    `CHK("dma0_cnt", 4, dma0)
  endtask

  task automatic t_updown;
    wr(A_CTL0, 32'h5c);
    tick(8'h20, 1'b0);
    `CHK("up_set", 1'b1, channel0_pin)
    tick(8'h00, 1'b0);
    `CHK("zero_clr", 1'b0, channel0_pin)
    wr(A_CTL0, 32'h64);
    tick(8'h00, 1'b0);
    `CHK("zero_set", 1'b1, channel0_pin)
    tick(8'h20, 1'b0);
    `CHK("up_clr", 1'b0, channel0_pin)
    @(posedge clk);
    timer_mode <= `TCC_MODE_UPDOWN;
    wr(A_CTL0, 32'h5c);
    tick(8'h20, 1'b0);
    `CHK("ud_up_set", 1'b1, channel0_pin)
    tick(8'h20, 1'b1);
    `CHK("ud_dn_clr", 1'b0, channel0_pin)
    wr(A_CTL0, 32'h64);
    tick(8'h20, 1'b1);
    `CHK("ud_dn_set", 1'b1, channel0_pin)
    tick(8'h20, 1'b0);
    `CHK("ud_up_clr", 1'b0, channel0_pin)
    @(posedge clk);
    timer_mode <= 2'h0;
  endtask

  task automatic t_alt;
    wr(A_CTL0, 32'h6c);
    tick(8'h20, 1'b0);
    `CHK("c0_101_m", 1'b1, channel0_pin)
    tick(8'hff, 1'b0);
    `CHK("c0_101_ff", 1'b0, channel0_pin)
    wr(A_CTL0, 32'h74);
    tick(8'h00, 1'b0);
    `CHK("c0_110_00", 1'b1, channel0_pin)
    tick(8'h20, 1'b0);
    `CHK("c0_110_m", 1'b0, channel0_pin)
    wr(A_CTL0, 32'h40);
    wr(A_VAL1, 32'h30);
    wr(A_CTL1, 32'h6c);
    tick(8'h30, 1'b0);
    `CHK("c1_101_m", 1'b1, channel1_pin)
    tick(8'h20, 1'b0);
    `CHK("c1_101_v0", 1'b0, channel1_pin)
    wr(A_CTL1, 32'h74);
    tick(8'h20, 1'b0);
    `CHK("c1_110_v0", 1'b1, channel1_pin)
    tick(8'h30, 1'b0);
    `CHK("c1_110_m", 1'b0, channel1_pin)
    wr(A_CTL1, 32'h40);
  endtask

  task automatic t_irq;
    int d1;
    wr(A_STAT, 32'h3);
    wr(A_CTL0, 32'h44);
    tick(8'h20, 1'b0);
    `CHK("flag0", 2'b01, shared_timer_flags)
    `CHK("irq_on", 1'b1, cpu_timer_irq_flag)
    rd_chk("status", A_STAT, 32'h1);
    wr(A_MASK, 32'h0);
    repeat (2) @(posedge clk);
    `CHK("irq_masked", 1'b0, cpu_timer_irq_flag)
    wr(A_MASK, 32'h3);
    repeat (2) @(posedge clk);
    `CHK("irq_unmask", 1'b1, cpu_timer_irq_flag)
    wr(A_STAT, 32'h1);
    repeat (2) @(posedge clk);
    `CHK("flag_w1c", 2'b00, shared_timer_flags)
    `CHK("irq_clr", 1'b0, cpu_timer_irq_flag)
    wr(A_CTL0, 32'h04);
    tick(8'h20, 1'b0);
    `CHK("flag_noie", 2'b01, shared_timer_flags)
    `CHK("irq_noie", 1'b0, cpu_timer_irq_flag)
    wr(A_CTL0, 32'h40);
    wr(A_STAT, 32'h1);
    d1 = dma1;
    wr(A_CTL1, 32'h44);
    tick(8'h30, 1'b0);
    `CHK("flag1", 2'b10, shared_timer_flags)
    `CHK("irq_ch1", 1'b1, cpu_timer_irq_flag)
    `CHK("dma1_one", d1 + 1, dma1)
  endtask

  task automatic summarize;
    if (mismatches == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0; sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; timer_tick = 1'b0; timer_count = 8'h80;
    timer_count_down = 1'b0; timer_mode = 2'h0;
    mismatches = 0; checks = 0; dma0 = 0; dma1 = 0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_basic();
    t_updown();
    t_alt();
    t_irq();
    summarize();
  end

  // The scenarios need well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    summarize();
  end
endmodule
